/* rtl/dss_pkg.sv */
// Shared constants, enumerations and carrier structs of the dual sensor supervisor.
`default_nettype none
package dss_pkg;
    localparam int TW = 16;
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 500;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int PERIOD_S = 60;
    localparam int PERIOD_TICKS = PERIOD_S * 1000 / TICK_MS;
    localparam logic [6:0] PW_NONE = 7'h00;
    localparam logic [6:0] PW_MAX = 7'h77;
    localparam logic [6:0] PW_CONT = 7'h7f;
    localparam logic [15:0] MASTER_PW = 16'h0110;
    localparam int GAIN_FRAC = 14;
    localparam logic signed [31:0] GAIN_UNITY = 32'sh0000_4000;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_WIRE1 = 8'h01;
    localparam logic [7:0] ERR_SENS2 = 8'h02;
    localparam logic [7:0] ERR_DRIFT = 8'h03;
    localparam logic [7:0] ERR_BOTH = 8'h04;

    typedef enum logic [2:0] {SEL_S1, SEL_S2, SEL_D12, SEL_D21, SEL_AVG, SEL_RED} dss_sel_e;
    typedef enum logic [1:0] {LVL_NORM, LVL_HIGH, LVL_LOW} dss_lvl_e;

    typedef struct packed {
        dss_sel_e outSel;
        logic faultHigh;
        logic [6:0] pulseCode;
        logic driftEn;
        logic mixedPair;
        logic [TW-1:0] driftMax;
        logic [15:0] driftTicks;
    } dss_cfg_s;

    typedef struct packed {
        logic trimLow;
        logic trimHigh;
        logic chan2;
        logic useS1Ref;
        logic signed [TW-1:0] setpoint;
    } dss_trim_s;
endpackage
`default_nettype wire

/* rtl/dss_sensor_adjust.sv */
// One- and two-point error adjustment of one linearized sensor channel.
`default_nettype none
module dss_sensor_adjust #(
    parameter int W = dss_pkg::TW
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Adjustment commands.
    input wire logic trimLow,
    input wire logic trimHigh,
    input wire logic signed [W-1:0] setpoint,
    // Temperatures.
    input wire logic signed [W-1:0] rawTemp,
    output logic signed [W-1:0] corrTemp
);
    localparam int F = dss_pkg::GAIN_FRAC;
    logic signed [W-1:0] refLow_ff, nxt_refLow;
    logic signed [W-1:0] measLow_ff, nxt_measLow;
    logic signed [31:0] gain_ff, nxt_gain;
    logic signed [W:0] devLow;
    logic signed [W:0] numDiff, denDiff;
    logic signed [W+F:0] num;
    logic signed [W+F:0] quot;
    logic signed [W+32:0] prod;
    logic signed [W+32:0] sum;

    always_comb begin
        // The deviation between setpoint and measurement becomes the offset of the characteristic.
        devLow = (W+1)'(setpoint) - (W+1)'(rawTemp);
        numDiff = (W+1)'(setpoint) - (W+1)'(refLow_ff);
        denDiff = (W+1)'(rawTemp) - (W+1)'(measLow_ff);
        num = (W+F+1)'(numDiff) <<< F;
        quot = (denDiff == '0) ? (W+F+1)'(dss_pkg::GAIN_UNITY) : num / (W+F+1)'(denDiff);
        nxt_refLow = refLow_ff;
        nxt_measLow = measLow_ff;
        nxt_gain = gain_ff;
        if (trimLow) begin
            // One point only shifts the offset and restores unity gradient.
            nxt_refLow = W'((W+1)'(rawTemp) + devLow);
            nxt_measLow = W'(rawTemp);
            nxt_gain = dss_pkg::GAIN_UNITY;
        end else if (trimHigh && denDiff != '0) begin
            // The second point sets the gradient through the stored low point.
            nxt_gain = 32'(quot);
        end
        prod = (W+33)'((W+1)'(rawTemp) - (W+1)'(measLow_ff)) * (W+33)'(gain_ff);
        sum = (W+33)'(refLow_ff) + (prod >>> F);
        corrTemp = W'(sum);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refLow_ff <= '0;
            measLow_ff <= '0;
            gain_ff <= dss_pkg::GAIN_UNITY;
        end else if (ce) begin
            refLow_ff <= nxt_refLow;
            measLow_ff <= nxt_measLow;
            gain_ff <= nxt_gain;
        end
    end
endmodule
`default_nettype wire

/* rtl/dss_supervisor.sv */
// Output selection, failure and drift supervision, alarm pulsing and write protection.
`default_nettype none
// What this block does
// - Redundancy: sensor 1 fails, switch to sensor 2.
// - Sensor 1 failure raises wire-break maintenance diagnostic.
// - Sensor 2 failure raises a diagnostic notification.
// - Redundancy with both healthy outputs the average.
// - Failure drives output to configured fault level.
// - Maintenance condition superimposes pulses at fault level.
// - Pulse width 0.5 to 59.5 s, 0.5 s steps.
// - Continuous level or no pulses also selectable.
// - Pulses repeat every 60 seconds.
// - Output carries exactly one configured value.
// - Drift only with two sensors, supported modes.
// - Drift flagged after deviation persists whole limit.
// - Drift raises maintenance, display letter, error code.
// - Drift uses the same alarm pulse mechanism.
// - Equivalent drift pair averages in redundancy mode.
// - Mixed pair: resistance on channel 1, output it.
// - Adjustment computes setpoint minus measured temperature.
// - One-point adjustment shifts offset only.
// - Two-point adjustment corrects offset and gradient.
// - Sensor 1 as setpoint aligns channel 2.
// - Master password unlocks; any other locks.
module dss_supervisor #(
    parameter int TICK_CYC = dss_pkg::TICK_CYC
) (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Sensor measurement channels.
    input wire logic sampleStb,
    input wire logic signed [dss_pkg::TW-1:0] s1Temp,
    input wire logic signed [dss_pkg::TW-1:0] s2Temp,
    input wire logic s1Fail,
    input wire logic s2Fail,
    // Configuration and commands from the host.
    input wire dss_pkg::dss_cfg_s cfg,
    input wire dss_pkg::dss_trim_s trim,
    input wire logic pwStb,
    input wire logic [15:0] pwValue,
    // Loop output.
    output logic signed [dss_pkg::TW-1:0] outTemp_ff,
    output dss_pkg::dss_lvl_e outLevel_ff,
    // Diagnostics.
    output logic maintReq_ff,
    output logic wireBreakDiag_ff,
    output logic sensor2Diag_ff,
    output logic driftFlag_ff,
    output logic dispMaint_ff,
    output logic [7:0] errCode_ff,
    output logic writeProt_ff
);
    localparam int TW = dss_pkg::TW;
    localparam int TCW = $clog2(TICK_CYC);
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYC - 1);
    localparam logic [6:0] PHASE_LAST = 7'(dss_pkg::PERIOD_TICKS - 1);

    logic signed [TW-1:0] t1, t2, sp2;
    logic [TCW-1:0] tickCnt_ff, nxt_tickCnt;
    logic tick;
    logic [6:0] phase_ff, nxt_phase;
    logic maintPrev_ff, nxt_maintPrev;
    logic [15:0] driftCnt_ff, nxt_driftCnt;
    logic signed [TW:0] diff12, absDiff;
    logic signed [TW:0] sum12;
    logic signed [TW-1:0] avgVal, selVal;
    logic srcFail, driftOk, overMax, maint, alarmOn, isRed;
    dss_pkg::dss_lvl_e faultLvl;
    logic signed [TW-1:0] nxt_outTemp;
    dss_pkg::dss_lvl_e nxt_outLevel;
    logic nxt_maintReq, nxt_wireBreak, nxt_s2Diag, nxt_drift, nxt_writeProt;
    logic [7:0] nxt_errCode;

    // Channel 2 may be aligned to the corrected sensor 1 value instead of a typed setpoint.
    assign sp2 = trim.useS1Ref ? t1 : trim.setpoint;

    dss_sensor_adjust #(.W(TW)) adj1 (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .trimLow(trim.trimLow && !trim.chan2 && !writeProt_ff),
        .trimHigh(trim.trimHigh && !trim.chan2 && !writeProt_ff),
        .setpoint(trim.setpoint),
        .rawTemp(s1Temp),
        .corrTemp(t1)
    );

    dss_sensor_adjust #(.W(TW)) adj2 (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .trimLow(trim.trimLow && trim.chan2 && !writeProt_ff),
        .trimHigh(trim.trimHigh && trim.chan2 && !writeProt_ff),
        .setpoint(sp2),
        .rawTemp(s2Temp),
        .corrTemp(t2)
    );

    // Free-running half-second tick; one divider serves pulses and drift alike.
    always_comb begin
        tick = (tickCnt_ff == TICK_LAST);
        nxt_tickCnt = tick ? '0 : tickCnt_ff + 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_ff <= '0;
        end else if (ce) begin
            tickCnt_ff <= nxt_tickCnt;
        end
    end

    // Value selection and failure supervision.
    always_comb begin
        isRed = (cfg.outSel == dss_pkg::SEL_RED);
        diff12 = (TW+1)'(t1) - (TW+1)'(t2);
        absDiff = diff12[TW] ? -diff12 : diff12;
        sum12 = (TW+1)'(t1) + (TW+1)'(t2);
        avgVal = TW'(sum12 >>> 1);
        faultLvl = cfg.faultHigh ? dss_pkg::LVL_HIGH : dss_pkg::LVL_LOW;
        selVal = outTemp_ff;
        srcFail = 1'b0;
        unique case (cfg.outSel)
            dss_pkg::SEL_S1: begin
                selVal = t1;
                srcFail = s1Fail;
            end
            dss_pkg::SEL_S2: begin
                selVal = t2;
                srcFail = s2Fail;
            end
            dss_pkg::SEL_D12: begin
                selVal = TW'(diff12);
                srcFail = s1Fail || s2Fail;
            end
            dss_pkg::SEL_D21: begin
                selVal = TW'(-diff12);
                srcFail = s1Fail || s2Fail;
            end
            dss_pkg::SEL_AVG: begin
                selVal = avgVal;
                srcFail = s1Fail || s2Fail;
            end
            dss_pkg::SEL_RED: begin
                // The surviving sensor takes over in the same refresh, so the failed reading is never output.
                if (s1Fail && s2Fail) begin
                    srcFail = 1'b1;
                end else if (s1Fail) begin
                    selVal = t2;
                end else if (s2Fail || cfg.mixedPair) begin
                    selVal = t1;
                end else begin
                    selVal = avgVal;
                end
            end
            default: begin
                srcFail = 1'b1;
            end
        endcase
        nxt_outTemp = sampleStb ? selVal : outTemp_ff;
    end

    // Drift persistence, maintenance state and alarm pulse sequencing.
    always_comb begin
        driftOk = cfg.driftEn && !s1Fail && !s2Fail && (cfg.outSel != dss_pkg::SEL_S1)
                  && (cfg.outSel != dss_pkg::SEL_S2);
        overMax = (absDiff > (TW+1)'(cfg.driftMax));
        nxt_driftCnt = driftCnt_ff;
        if (!driftOk || !overMax) begin
            nxt_driftCnt = '0;
        end else if (tick && driftCnt_ff != 16'hffff) begin
            nxt_driftCnt = driftCnt_ff + 16'h0001;
        end
        nxt_drift = driftOk && overMax && (driftCnt_ff >= cfg.driftTicks);
        maint = (isRed && (s1Fail || s2Fail)) || driftFlag_ff;
        nxt_maintPrev = maint;
        nxt_phase = phase_ff;
        if (maint && !maintPrev_ff) begin
            nxt_phase = '0;
        end else if (tick) begin
            nxt_phase = (phase_ff == PHASE_LAST) ? '0 : phase_ff + 7'h01;
        end
        if (cfg.pulseCode == dss_pkg::PW_NONE) begin
            alarmOn = 1'b0;
        end else if (cfg.pulseCode > dss_pkg::PW_MAX) begin
            alarmOn = 1'b1;
        end else begin
            alarmOn = (phase_ff < cfg.pulseCode);
        end
        if (srcFail) begin
            nxt_outLevel = faultLvl;
        end else if (maint && alarmOn) begin
            nxt_outLevel = faultLvl;
        end else begin
            nxt_outLevel = dss_pkg::LVL_NORM;
        end
        nxt_maintReq = maint;
        nxt_wireBreak = isRed && s1Fail;
        nxt_s2Diag = isRed && s2Fail;
        if (isRed && s1Fail && s2Fail) begin
            nxt_errCode = dss_pkg::ERR_BOTH;
        end else if (nxt_wireBreak) begin
            nxt_errCode = dss_pkg::ERR_WIRE1;
        end else if (nxt_s2Diag) begin
            nxt_errCode = dss_pkg::ERR_SENS2;
        end else if (driftFlag_ff) begin
            nxt_errCode = dss_pkg::ERR_DRIFT;
        end else begin
            nxt_errCode = dss_pkg::ERR_NONE;
        end
        // The master value is fixed in logic, so no store can ever change it.
        nxt_writeProt = writeProt_ff;
        if (pwStb) begin
            nxt_writeProt = (pwValue != dss_pkg::MASTER_PW);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outTemp_ff <= '0;
            outLevel_ff <= dss_pkg::LVL_NORM;
            maintReq_ff <= 1'b0;
            wireBreakDiag_ff <= 1'b0;
            sensor2Diag_ff <= 1'b0;
            driftFlag_ff <= 1'b0;
            dispMaint_ff <= 1'b0;
            errCode_ff <= dss_pkg::ERR_NONE;
            writeProt_ff <= 1'b0;
            driftCnt_ff <= '0;
            phase_ff <= '0;
            maintPrev_ff <= 1'b0;
        end else if (ce) begin
            outTemp_ff <= nxt_outTemp;
            outLevel_ff <= nxt_outLevel;
            maintReq_ff <= nxt_maintReq;
            wireBreakDiag_ff <= nxt_wireBreak;
            sensor2Diag_ff <= nxt_s2Diag;
            driftFlag_ff <= nxt_drift;
            dispMaint_ff <= nxt_maintReq;
            errCode_ff <= nxt_errCode;
            writeProt_ff <= nxt_writeProt;
            driftCnt_ff <= nxt_driftCnt;
            phase_ff <= nxt_phase;
            maintPrev_ff <= nxt_maintPrev;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence redS1Lost;
        ce && sampleStb && isRed && s1Fail && !s2Fail;
    endsequence
    sequence redBothOk;
        ce && sampleStb && isRed && !s1Fail && !s2Fail && !cfg.mixedPair;
    endsequence
    sequence pwMaster;
        ce && pwStb && pwValue == dss_pkg::MASTER_PW;
    endsequence

    a_red_fail_switch: assert property (redS1Lost |=> outTemp_ff == $past(t2))
        else $error("redundancy did not switch to sensor 2");
    a_wire_break_diag: assert property (ce && isRed && s1Fail |=> wireBreakDiag_ff && errCode_ff != 8'h00)
        else $error("wire break diagnostic missing");
    a_sensor2_diag: assert property (ce && isRed && s2Fail |=> sensor2Diag_ff && maintReq_ff)
        else $error("sensor 2 diagnostic missing");
    a_red_average: assert property (redBothOk |=> outTemp_ff == $past(avgVal))
        else $error("redundancy output is not the average");
    a_fault_level: assert property (ce && srcFail |=> outLevel_ff ==
        ($past(cfg.faultHigh) ? dss_pkg::LVL_HIGH : dss_pkg::LVL_LOW))
        else $error("failed source not at fault level");
    a_no_pulse_mode: assert property (ce && !srcFail && cfg.pulseCode == 7'h00
        |=> outLevel_ff == dss_pkg::LVL_NORM)
        else $error("pulse shown while pulses disabled");
    a_pulse_width: assert property (ce && !srcFail && maint && cfg.pulseCode <= 7'h77 && phase_ff >= cfg.pulseCode
        |=> outLevel_ff == dss_pkg::LVL_NORM)
        else $error("alarm pulse longer than width");
    a_mixed_channel1: assert property (ce && sampleStb && isRed && cfg.mixedPair && !s1Fail
        |=> outTemp_ff == $past(t1))
        else $error("mixed pair not output from channel 1");
    a_drift_persist: assert property ($rose(driftFlag_ff) |-> $past(driftCnt_ff) >= $past(cfg.driftTicks)
        && $past(overMax))
        else $error("drift flagged before time limit");
    a_master_unlock: assert property (pwMaster |=> !writeProt_ff)
        else $error("master password did not unlock");
    a_phase_wrap: assert property (ce && tick && phase_ff == 7'h77 && !(maint && !maintPrev_ff)
        |=> phase_ff == 7'h00)
        else $error("pulse period is not 60 s");
endmodule
`default_nettype wire

/* tb/dss_sensor_model.sv */
// Behavioural model of the two sensor measurement channels that feed the supervisor.
`default_nettype none
module dss_sensor_model #(
    parameter int REFRESH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Channel states commanded by the bench.
    input wire logic signed [dss_pkg::TW-1:0] t1,
    input wire logic signed [dss_pkg::TW-1:0] t2,
    input wire logic f1,
    input wire logic f2,
    // Channel outputs.
    output logic sampleStb,
    output logic signed [dss_pkg::TW-1:0] s1Temp,
    output logic signed [dss_pkg::TW-1:0] s2Temp,
    output logic s1Fail,
    output logic s2Fail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic signed [dss_pkg::TW-1:0] last1;
    logic signed [dss_pkg::TW-1:0] last2;
    // A broken wire reads as garbage, so a failed channel shows the inverse of its last good value.
    assign s1Temp = f1 ? ~last1 : t1;
    assign s2Temp = f2 ? ~last2 : t2;
    assign s1Fail = f1;
    assign s2Fail = f2;
    always_ff @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h00;
            sampleStb <= 1'b0;
            last1 <= 16'sh0000;
            last2 <= 16'sh0000;
        end else begin
            cnt <= (cnt == 8'(REFRESH - 1)) ? 8'h00 : cnt + 8'h01;
            sampleStb <= (cnt == 8'(REFRESH - 1));
            if (!f1) last1 <= t1;
            if (!f2) last2 <= t2;
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench of the dual sensor supervisor.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic signed [15:0] t1 = 16'sh0064;
    logic signed [15:0] t2 = 16'sh0028;
    logic f1 = 1'b0;
    logic f2 = 1'b0;
    logic pwStb = 1'b0;
    logic [15:0] pwValue = 16'h0000;
    dss_pkg::dss_cfg_s cfg = '0;
    dss_pkg::dss_trim_s trim = '0;
    logic sampleStb, s1Fail, s2Fail, maintReq, wireDiag, s2Diag, drift, dispM, wProt;
    logic signed [15:0] s1Temp, s2Temp, outTemp;
    dss_pkg::dss_lvl_e outLevel;
    logic [7:0] errCode;
    int nFail = 0;
    int checksDone = 0;

    dss_sensor_model dss_sensor_model_i (.clk(clk), .rstn(rstn), .t1(t1), .t2(t2), .f1(f1), .f2(f2),
        .sampleStb(sampleStb), .s1Temp(s1Temp), .s2Temp(s2Temp), .s1Fail(s1Fail), .s2Fail(s2Fail));
    dss_supervisor #(.TICK_CYC(4)) dss_supervisor_i (.clk(clk), .rstn(rstn), .ce(ce),
        .sampleStb(sampleStb), .s1Temp(s1Temp), .s2Temp(s2Temp), .s1Fail(s1Fail), .s2Fail(s2Fail),
        .cfg(cfg), .trim(trim), .pwStb(pwStb), .pwValue(pwValue), .outTemp_ff(outTemp),
        .outLevel_ff(outLevel), .maintReq_ff(maintReq), .wireBreakDiag_ff(wireDiag),
        .sensor2Diag_ff(s2Diag), .driftFlag_ff(drift), .dispMaint_ff(dispM), .errCode_ff(errCode),
        .writeProt_ff(wProt));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] want);
        checksDone++;
        if (seen !== want) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Two refresh strobes guarantee the output reflects the current inputs.
    task automatic refresh();
        repeat (2) @(posedge clk iff sampleStb);
        cyc(1);
    endtask

    task automatic pw(input logic [15:0] v);
        pwStb = 1'b1;
        pwValue = v;
        cyc(1);
        pwStb = 1'b0;
        cyc(1);
    endtask

    task automatic trimCmd(input logic lo, input logic [15:0] sp);
        trim.setpoint = sp;
        trim.trimLow = lo;
        trim.trimHigh = !lo;
        cyc(1);
        trim.trimLow = 1'b0;
        trim.trimHigh = 1'b0;
        refresh();
    endtask

    task automatic test_select();
        logic [15:0] want [5];
        want = '{16'h0064, 16'h0028, 16'h003c, 16'hffc4, 16'h0046};
        for (int i = 0; i < 5; i++) begin
            cfg.outSel = dss_pkg::dss_sel_e'(i);
            refresh();
            chk("outTemp", outTemp, want[i]);
        end
    endtask

    task automatic test_redundancy();
        cfg.outSel = dss_pkg::SEL_RED;
        cfg.faultHigh = 1'b1;
        cfg.pulseCode = 7'h02;
        refresh();
        chk("outTemp avg", outTemp, 16'h0046);
        f1 = 1'b1;
        cyc(3);
        chk("level pulse", outLevel, dss_pkg::LVL_HIGH);
        chk("wireBreak", {wireDiag, maintReq}, 16'h0003);
        chk("errCode", errCode, dss_pkg::ERR_WIRE1);
        cyc(6);
        chk("outTemp s2", outTemp, 16'h0028);
        cyc(11);
        chk("level gap", outLevel, dss_pkg::LVL_NORM);
        cyc(465);
        chk("level repeat", outLevel, dss_pkg::LVL_HIGH);
        cfg.faultHigh = 1'b0;
        cfg.pulseCode = dss_pkg::PW_CONT;
        cyc(300);
        chk("level cont", outLevel, dss_pkg::LVL_LOW);
        cfg.pulseCode = dss_pkg::PW_NONE;
        cyc(2);
        chk("level none", outLevel, dss_pkg::LVL_NORM);
        f1 = 1'b0;
        f2 = 1'b1;
        cyc(3);
        chk("s2 diag", {s2Diag, wireDiag}, 16'h0002);
        chk("errCode", errCode, dss_pkg::ERR_SENS2);
        f1 = 1'b1;
        cyc(3);
        chk("errCode", errCode, dss_pkg::ERR_BOTH);
        chk("level fail", outLevel, dss_pkg::LVL_LOW);
        f1 = 1'b0;
        f2 = 1'b0;
        cfg.mixedPair = 1'b1;
        refresh();
        chk("outTemp mixed", outTemp, 16'h0064);
        cfg.mixedPair = 1'b0;
    endtask

    task automatic test_drift();
        cfg.outSel = dss_pkg::SEL_AVG;
        cfg.faultHigh = 1'b1;
        cfg.pulseCode = dss_pkg::PW_CONT;
        t2 = 16'sh005f;
        cfg.driftEn = 1'b1;
        cfg.driftMax = 16'h000a;
        cfg.driftTicks = 16'h0003;
        cyc(20);
        chk("drift", drift, 16'h0000);
        t2 = 16'sh0028;
        cyc(6);
        chk("drift early", drift, 16'h0000);
        cyc(14);
        chk("drift", drift, 16'h0001);
        chk("maint disp", {maintReq, dispM}, 16'h0003);
        chk("errCode", errCode, dss_pkg::ERR_DRIFT);
        chk("level", outLevel, dss_pkg::LVL_HIGH);
        cfg.outSel = dss_pkg::SEL_S1;
        cyc(20);
        chk("drift S1", drift, 16'h0000);
        cfg.outSel = dss_pkg::SEL_RED;
        f2 = 1'b1;
        cyc(20);
        chk("drift fail", drift, 16'h0000);
        f2 = 1'b0;
        t2 = 16'sh005a;
        refresh();
        chk("outTemp avg", outTemp, 16'h005f);
        cfg.driftEn = 1'b0;
    endtask

    task automatic test_trim();
        cfg.outSel = dss_pkg::SEL_S2;
        t2 = 16'sh005a;
        trim.chan2 = 1'b1;
        trim.useS1Ref = 1'b1;
        pw(16'h1234);
        chk("writeProt", wProt, 16'h0001);
        trimCmd(1'b1, 16'h0000);
        chk("outTemp locked", outTemp, 16'h005a);
        pw(16'h0110);
        chk("writeProt", wProt, 16'h0000);
        trimCmd(1'b1, 16'h0000);
        chk("outTemp ch2", outTemp, 16'h0064);
        t2 = 16'sh0078;
        refresh();
        chk("outTemp ch2", outTemp, 16'h0082);
        cfg.outSel = dss_pkg::SEL_S1;
        trim.chan2 = 1'b0;
        trim.useS1Ref = 1'b0;
        trimCmd(1'b1, 16'h006e);
        chk("outTemp low", outTemp, 16'h006e);
        t1 = 16'sh012c;
        trimCmd(1'b0, 16'h019a);
        chk("outTemp high", outTemp, 16'h019a);
        t1 = 16'sh00c8;
        refresh();
        chk("outTemp gain", outTemp, 16'h0104);
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        chk("outTemp rst", outTemp, 16'h0000);
        chk("flags rst", {outLevel, maintReq, wireDiag, s2Diag, drift, wProt}, 16'h0000);
        chk("errCode rst", errCode, dss_pkg::ERR_NONE);
        cyc(1);
        test_select();
        test_redundancy();
        test_drift();
        test_trim();
        finish_test();
    end

    // The scenarios need about 1100 cycles; a run far beyond that is hung.
    initial begin
        repeat (6000) @(posedge clk);
        nFail++;
        $display("Watchdog expired");
        finish_test();
    end
endmodule
`default_nettype wire
